/* File: verilog/lcm_pkg.sv */
// Purpose: shared constants for the logical channel manager
// Assumes: channel number in the two low bits of the class byte
// Notes:   status words and instruction codes are plain values
package lcm_pkg;
  localparam int            NUM_CHAN      = 4;
  localparam int            CHAN_W        = 2;
  localparam logic [7:0]    INS_MANAGE    = 8'h0070;
  localparam logic [7:0]    INS_STATUS    = 8'h00F2;
  localparam logic [7:0]    INS_READ_REC  = 8'h00B2;
  localparam logic [7:0]    P1_OPEN       = 8'h0000;
  localparam logic [7:0]    P1_CLOSE      = 8'h0080;
  localparam logic [15:0]   SW_OK         = 16'h9000;
  localparam logic [15:0]   SW_CHAN_BAD   = 16'h6881;
  localparam logic [15:0]   SW_NO_EF      = 16'h6986;
  localparam logic [15:0]   SW_NOT_ALLOW  = 16'h6A81;
  localparam logic [15:0]   SW_FWD        = 16'h0000;
  localparam logic [15:0]   DIR_ROOT      = 16'h3F00;
  localparam logic [15:0]   FILE_NONE     = 16'hFFFF;
  localparam logic [7:0]    CAP_NONE      = 8'h0000;
  localparam int            CAP_SUP_BIT   = 7;
  localparam int            CAP_ASSIGN_BIT = 6;
  localparam int            CAP_MAX_LSB   = 0;
  localparam logic [7:0]    CLA_CHAN_MASK = 8'h0003;
  localparam logic [2:0]    CTX_APP_UNDEF = 3'h0;
endpackage : lcm_pkg

/* File: verilog/lcm_ctx_mem.sv */
// Purpose: per-channel file context store, registered read
// Assumes: one write and one read per cycle
// Notes:   context = current directory, elementary file, application
`timescale 1ns/1ps
module lcm_ctx_mem #(
  parameter int DEPTH = 4,
  parameter int AW    = 2,
  parameter int DW    = 35
) (
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // lcm_ctx_mem

/* File: verilog/logical_channel_manager.sv */
// Purpose: command-level logical channel manager of a card
// Assumes: one command at a time; next command only after the answer
// Notes:   commands not handled here are forwarded with a channel context
`timescale 1ns/1ps

module logical_channel_manager
  import lcm_pkg::*;
#(
  parameter int  MAX_CHAN  = lcm_pkg::NUM_CHAN,
  parameter bit  SUPPORTED = 1'b1
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  input  wire logic        I_CMD_VALID,
  input  wire logic [7:0]  I_CMD_CLA,
  input  wire logic [7:0]  I_CMD_INS,
  input  wire logic [7:0]  I_CMD_P1,
  input  wire logic [7:0]  I_CMD_P2,
  output logic             O_CMD_READY,
  output logic             O_RSP_VALID,
  output logic [15:0]      O_RSP_SW,
  output logic             O_RSP_HAS_DATA,
  output logic [7:0]       O_RSP_DATA,
  output logic             O_FWD_VALID,
  output logic [1:0]       O_FWD_CHAN,
  output logic [15:0]      O_FWD_DIR,
  output logic [15:0]      O_FWD_FILE,
  output logic [2:0]       O_FWD_APP,
  output logic [3:0]       O_CHAN_OPEN,
  output logic [7:0]       O_ATR_CAP
);
  import lcm_pkg::*;

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (MAX_CHAN < 2 || MAX_CHAN > NUM_CHAN) begin : g_bad_max
    $error("MAX_CHAN must lie from 2 to 4");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ANSWER} state_t;

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ***************************************************************
  // decoding helpers
  // ***************************************************************
  function automatic logic [1:0] chan_of(input logic [7:0] cla);
    chan_of = 2'(cla & CLA_CHAN_MASK);
  endfunction

  function automatic logic [2:0] free_count(input logic [3:0] open);
    free_count = 3'd0;
    for (int k = 1; k < MAX_CHAN; k++) begin
      free_count = free_count + 3'(!open[k]);
    end
  endfunction

  // ***************************************************************
  // command capture
  // ***************************************************************
  state_t      state_r;
  logic [1:0]  chan_r;
  logic [7:0]  ins_r;
  logic [7:0]  p1_r;
  logic [7:0]  p2_r;
  logic [3:0]  open_r;
  logic [1:0]  pick;
  logic        pick_ok;
  logic [34:0] ctx_rd;
  logic        ctx_we;
  logic [1:0]  ctx_waddr;
  logic [34:0] ctx_wdata;
  logic        init_r;

  // lowest free extra channel among the supported ones
  always_comb begin
    pick    = 2'd0;
    pick_ok = 1'b0;
    for (int k = MAX_CHAN - 1; k >= 1; k--) begin
      if (!open_r[k]) begin
        pick    = 2'(k);
        pick_ok = 1'b1;
      end
    end
  end

  // one command in flight; ready only in idle
  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
    end else if (I_CE) begin
      case (state_r)
        ST_IDLE:   state_r <= (I_CMD_VALID) ? ST_READ : ST_IDLE;
        ST_READ:   state_r <= ST_ANSWER;
        ST_ANSWER: state_r <= ST_IDLE;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chan_r <= 2'd0;
      ins_r  <= 8'h00;
      p1_r   <= 8'h00;
      p2_r   <= 8'h00;
    end else if (I_CE && state_r == ST_IDLE && I_CMD_VALID) begin
      chan_r <= chan_of(I_CMD_CLA);
      ins_r  <= I_CMD_INS;
      p1_r   <= I_CMD_P1;
      p2_r   <= I_CMD_P2;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_CMD_READY <= 1'b0;
    end else if (I_CE) begin
      O_CMD_READY <= (state_r == ST_IDLE) && !I_CMD_VALID ||
                     (state_r == ST_ANSWER);
    end
  end

  // ***************************************************************
  // command decision (in ST_ANSWER, context already read)
  // ***************************************************************
  logic        is_manage;
  logic        is_open;
  logic        is_close;
  logic        chan_live;
  logic [1:0]  close_tgt;
  logic        do_open;
  logic        do_close;

  assign is_manage = (ins_r == INS_MANAGE);
  assign is_open   = is_manage && (p1_r == P1_OPEN);
  assign is_close  = is_manage && (p1_r == P1_CLOSE);
  assign chan_live = open_r[chan_r];
  assign close_tgt = (p2_r[1:0] != 2'd0) ? p2_r[1:0] : chan_r;
  assign do_open   = (state_r == ST_ANSWER) && SUPPORTED && is_open && chan_live &&
                     pick_ok;
  assign do_close  = (state_r == ST_ANSWER) && SUPPORTED && is_close && chan_live &&
                     close_tgt != 2'd0 && open_r[close_tgt];

  // channel 0 is held open; others change only by open, close or reset
  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      open_r <= 4'b0001;
    end else if (I_CE) begin
      if (do_open) begin
        open_r[pick] <= 1'b1;
      end else if (do_close) begin
        open_r[close_tgt] <= 1'b0;
      end
      open_r[0] <= 1'b1;
    end
  end

  // ***************************************************************
  // per-channel file context
  // ***************************************************************
  // new channel from basic: root dir, no file, undefined app;
  // from an extra channel it inherits that channel's directory and application, with no file
  // channel 0 gets the root context once after each reset, never unknowns
  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      init_r <= 1'b1;
    end else if (I_CE) begin
      init_r <= 1'b0;
    end
  end

  assign ctx_we    = do_open || init_r;
  assign ctx_waddr = (init_r) ? 2'd0 : pick;
  assign ctx_wdata = (init_r || chan_r == 2'd0) ?
                     {DIR_ROOT, FILE_NONE, CTX_APP_UNDEF} :
                     {ctx_rd[34:19], FILE_NONE, ctx_rd[2:0]};

  lcm_ctx_mem #(
    .DEPTH (NUM_CHAN),
    .AW    (CHAN_W),
    .DW    (35)
  ) u_ctx (
    .i_clk   (I_CLK_SYS),
    .i_ce    (I_CE),
    .i_we    (ctx_we),
    .i_waddr (ctx_waddr),
    .i_wdata (ctx_wdata),
    .i_raddr ((state_r == ST_IDLE) ? chan_of(I_CMD_CLA) : chan_r),
    .o_rdata (ctx_rd)
  );

  // ***************************************************************
  // answer
  // ***************************************************************
  logic [15:0] sw_nxt;
  logic        fwd_nxt;

  always_comb begin
    sw_nxt  = SW_FWD;
    fwd_nxt = 1'b0;
    if (!chan_live || (!SUPPORTED && chan_r != 2'd0)) begin
      sw_nxt = SW_CHAN_BAD;
    end else if (is_open) begin
      sw_nxt = (do_open) ? SW_OK : SW_NOT_ALLOW;
    end else if (is_close) begin
      sw_nxt = (do_close) ? SW_OK : SW_NOT_ALLOW;
    end else if (ins_r == INS_STATUS) begin
      sw_nxt = SW_OK;
    end else if (ins_r == INS_READ_REC && ctx_rd[18:3] == FILE_NONE) begin
      sw_nxt = SW_NO_EF;
    end else begin
      fwd_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_RSP_VALID    <= 1'b0;
      O_RSP_SW       <= 16'h0000;
      O_RSP_HAS_DATA <= 1'b0;
      O_RSP_DATA     <= 8'h00;
      O_FWD_VALID    <= 1'b0;
      O_FWD_CHAN     <= 2'd0;
      O_FWD_DIR      <= 16'h0000;
      O_FWD_FILE     <= 16'h0000;
      O_FWD_APP      <= 3'd0;
    end else if (I_CE) begin
      O_RSP_VALID    <= (state_r == ST_ANSWER) && !fwd_nxt;
      O_FWD_VALID    <= (state_r == ST_ANSWER) && fwd_nxt;
      O_RSP_HAS_DATA <= do_open;
      if (state_r == ST_ANSWER) begin
        O_RSP_SW   <= sw_nxt;
        O_RSP_DATA <= (do_open) ? {6'd0, pick} : 8'h00;
        O_FWD_CHAN <= chan_r;
        O_FWD_DIR  <= ctx_rd[34:19];
        O_FWD_FILE <= ctx_rd[18:3];
        O_FWD_APP  <= ctx_rd[2:0];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_CHAN_OPEN <= 4'b0001;
      O_ATR_CAP   <= CAP_NONE;
    end else if (I_CE) begin
      O_CHAN_OPEN <= open_r;
      O_ATR_CAP   <= (SUPPORTED) ? (8'(1) << CAP_SUP_BIT | 8'(1) << CAP_ASSIGN_BIT |
                                    8'(MAX_CHAN) << CAP_MAX_LSB) : CAP_NONE;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_open_req;
    state_r == ST_ANSWER && do_open;
  endsequence

  property p_basic_open;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r) I_CE |-> open_r[0];
  endproperty
  a_basic_open: assert property (p_basic_open) else $error("channel 0 closed");

  property p_open_answer;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      s_open_req and I_CE |=> O_RSP_VALID && O_RSP_HAS_DATA && O_RSP_SW == SW_OK &&
      O_RSP_DATA[1:0] != 2'd0 && open_r[O_RSP_DATA[1:0]];
  endproperty
  a_open_answer: assert property (p_open_answer) else $error("open answer wrong");

  property p_full_refused;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      I_CE && state_r == ST_ANSWER && is_open && !pick_ok |=> $stable(open_r) &&
      O_RSP_SW == SW_NOT_ALLOW;
  endproperty
  a_full_refused: assert property (p_full_refused) else $error("open when full");

  property p_closed_refused;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      I_CE && state_r == ST_ANSWER && !chan_live |=> O_RSP_VALID && !O_FWD_VALID &&
      O_RSP_SW == SW_CHAN_BAD;
  endproperty
  a_closed_refused: assert property (p_closed_refused) else $error("closed chan ran");

  property p_status_ok;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      I_CE && state_r == ST_ANSWER && ins_r == INS_STATUS && chan_r == 2'd0
      |=> O_RSP_SW == SW_OK;
  endproperty
  a_status_ok: assert property (p_status_ok) else $error("status not 90 00");

  property p_close_frees;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      I_CE && do_close |=> !open_r[$past(close_tgt)] && O_RSP_SW == SW_OK;
  endproperty
  a_close_frees: assert property (p_close_frees) else $error("close failed");

  property p_one_cmd;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      I_CE && state_r == ST_READ |-> !O_CMD_READY;
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("second command taken");

  property p_root_ctx;
    @(posedge I_CLK_SYS) disable iff (!rst_n_r)
      do_open && chan_r == 2'd0 |-> ctx_wdata[34:19] == DIR_ROOT &&
      ctx_wdata[18:3] == FILE_NONE && ctx_wdata[2:0] == CTX_APP_UNDEF;
  endproperty
  a_root_ctx: assert property (p_root_ctx) else $error("new context wrong");
endmodule // logical_channel_manager

/* File: verification/lcm_terminal_model.sv */
// Purpose: terminal model offering command headers to the channel manager
// Assumes: one command at a time; the answer comes within eight cycles
// Notes:   header lines carry the last header inverted between commands, zeros before the first
`timescale 1ns/1ps
module lcm_terminal_model (
  input  wire logic       i_clk,
  input  wire logic       i_rsp_valid,
  input  wire logic       i_fwd_valid,
  output logic            o_valid,
  output logic [7:0]      o_cla,
  output logic [7:0]      o_ins,
  output logic [7:0]      o_p1,
  output logic [7:0]      o_p2
);
  initial begin
    o_valid = 1'b0;
    {o_cla, o_ins, o_p1, o_p2} = 32'h0000_0000;
  end

  // ****************************************************
  // one command: offered for one cycle, then wait for the answer
  // ****************************************************
  task automatic send(input logic [31:0] hdr, output logic [1:0] kind);
    kind = 2'h0;
    @(posedge i_clk);
    o_valid <= 1'b1;
    {o_cla, o_ins, o_p1, o_p2} <= hdr;
    @(posedge i_clk);
    o_valid <= 1'b0;
    {o_cla, o_ins, o_p1, o_p2} <= ~hdr;
    for (int n = 0; n < 8 && kind == 2'h0; n++) begin
      @(negedge i_clk);
      kind = {i_fwd_valid === 1'b1, i_rsp_valid === 1'b1};
    end
  endtask
endmodule // lcm_terminal_model

/* File: verification/logical_channel_manager_tb.sv */
// Purpose: self-checking bench for the logical channel manager
// Assumes: both instances see the same commands; the second has no channel support
// Notes:   expectations come from package constants and the scenario itself
`timescale 1ns/1ps
module logical_channel_manager_tb;
  import lcm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        valid, rsp_a, fwd_a, hasd_a, rdy_a;
  logic [7:0]  cla, ins, p1, p2, data_a, cap_a, cap_b;
  logic [15:0] sw_a, sw_b, dir_a, file_a;
  logic [3:0]  open_a, open_b;
  logic [2:0]  app_a;
  logic [1:0]  ch_a, kind;
  int          fail_count = 0;
  int          checks = 0;

  always #2 clk = ~clk;

  logical_channel_manager i_logical_channel_manager (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_CMD_VALID(valid),
    .I_CMD_CLA(cla), .I_CMD_INS(ins), .I_CMD_P1(p1), .I_CMD_P2(p2),
    .O_CMD_READY(rdy_a), .O_RSP_VALID(rsp_a), .O_RSP_SW(sw_a), .O_RSP_HAS_DATA(hasd_a),
    .O_RSP_DATA(data_a), .O_FWD_VALID(fwd_a), .O_FWD_CHAN(ch_a), .O_FWD_DIR(dir_a),
    .O_FWD_FILE(file_a), .O_FWD_APP(app_a), .O_CHAN_OPEN(open_a), .O_ATR_CAP(cap_a));

  logical_channel_manager #(.SUPPORTED(1'b0)) i_logical_channel_manager_nosup (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_CMD_VALID(valid),
    .I_CMD_CLA(cla), .I_CMD_INS(ins), .I_CMD_P1(p1), .I_CMD_P2(p2),
    .O_CMD_READY(), .O_RSP_VALID(), .O_RSP_SW(sw_b), .O_RSP_HAS_DATA(),
    .O_RSP_DATA(), .O_FWD_VALID(), .O_FWD_CHAN(), .O_FWD_DIR(),
    .O_FWD_FILE(), .O_FWD_APP(), .O_CHAN_OPEN(open_b), .O_ATR_CAP(cap_b));

  lcm_terminal_model i_lcm_terminal_model (
    .i_clk(clk), .i_rsp_valid(rsp_a), .i_fwd_valid(fwd_a), .o_valid(valid),
    .o_cla(cla), .o_ins(ins), .o_p1(p1), .o_p2(p2));

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // locally answered command with its expected status word
  task automatic cmd(input logic [1:0] ch, input logic [7:0] i, input logic [7:0] a,
                     input logic [7:0] b, input logic [15:0] exp);
    i_lcm_terminal_model.send({6'h00, ch, i, a, b}, kind);
    chk({14'h0000, kind}, 16'h0001);
    chk(sw_a, exp);
    chk({15'h0000, rdy_a}, 16'h0001);
  endtask

  // a command offered while the enable is low is not taken
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    i_lcm_terminal_model.send({8'h00, INS_MANAGE, P1_OPEN, 8'h00}, kind);
    chk({14'h0000, kind}, 16'h0000);
    chk({12'h000, open_a}, 16'h0001);
    @(posedge clk);
    ce <= 1'b1;
    cmd(2'h0, INS_STATUS, 8'h00, 8'h00, SW_OK);
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_atr();
    chk({11'h000, cap_a[CAP_SUP_BIT], cap_a[CAP_ASSIGN_BIT], cap_a[2:0]}, 16'h001C);
    chk({12'h000, open_a}, 16'h0001);
    chk({8'h00, cap_b}, {8'h00, CAP_NONE});
  endtask

  task automatic t_basic();
    cmd(2'h0, INS_MANAGE, P1_CLOSE, 8'h00, SW_NOT_ALLOW);
    cmd(2'h0, INS_STATUS, 8'h00, 8'h00, SW_OK);
    chk({12'h000, open_a}, 16'h0001);
    for (int k = 1; k < 4; k++) begin
      cmd(2'(k), INS_STATUS, 8'h00, 8'h00, SW_CHAN_BAD);
      chk(sw_b, SW_CHAN_BAD);
    end
  endtask

  task automatic t_fill();
    for (int k = 1; k < 4; k++) begin
      cmd(2'h0, INS_MANAGE, P1_OPEN, 8'h00, SW_OK);
      chk({15'h0000, hasd_a}, 16'h0001);
      chk({8'h00, data_a}, 16'(k));
      chk(sw_b, SW_NOT_ALLOW);
      cmd(2'(k), INS_STATUS, 8'h00, 8'h00, SW_OK);
    end
    chk({12'h000, open_a}, 16'h000F);
    chk({12'h000, open_b}, 16'h0001);
    cmd(2'h0, INS_MANAGE, P1_OPEN, 8'h00, SW_NOT_ALLOW);
    chk({15'h0000, hasd_a}, 16'h0000);
    repeat (2) @(posedge clk);
    chk({12'h000, open_a}, 16'h000F);
  endtask

  task automatic t_close();
    for (int k = 1; k < 4; k++) begin
      cmd(2'(k), INS_MANAGE, P1_CLOSE, 8'h00, SW_OK);
      cmd(2'(k), INS_STATUS, 8'h00, 8'h00, SW_CHAN_BAD);
    end
    chk({12'h000, open_a}, 16'h0001);
  endtask

  task automatic t_ctx();
    cmd(2'h0, INS_MANAGE, P1_OPEN, 8'h00, SW_OK);
    chk({8'h00, data_a}, 16'h0001);
    i_lcm_terminal_model.send({8'h01, 8'hA4, 8'h00, 8'h00}, kind);
    chk({14'h0000, kind}, 16'h0002);
    chk({14'h0000, ch_a}, 16'h0001);
    chk(dir_a, DIR_ROOT);
    chk(file_a, FILE_NONE);
    chk({13'h0000, app_a}, {13'h0000, CTX_APP_UNDEF});
    cmd(2'h1, INS_READ_REC, 8'h01, 8'h04, SW_NO_EF);
    cmd(2'h1, INS_MANAGE, P1_OPEN, 8'h00, SW_OK);
    chk({8'h00, data_a}, 16'h0002);
    cmd(2'h2, INS_STATUS, 8'h00, 8'h00, SW_OK);
    cmd(2'h3, 8'hA4, 8'h00, 8'h00, SW_CHAN_BAD);
    do_reset();
    chk({12'h000, open_a}, 16'h0001);
    cmd(2'h1, INS_STATUS, 8'h00, 8'h00, SW_CHAN_BAD);
    i_lcm_terminal_model.send({8'h00, 8'hA4, 8'h00, 8'h00}, kind);
    chk({14'h0000, kind}, 16'h0002);
    chk({14'h0000, ch_a}, 16'h0000);
    chk(dir_a, DIR_ROOT);
  endtask

  initial begin
    do_reset();
    t_atr();
    t_freeze();
    t_basic();
    t_fill();
    t_close();
    t_ctx();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule // logical_channel_manager_tb
